// file: design/vbc_read_port.sv
// Registered read-data path of the video buffer control register bank
`timescale 1ns/1ps
module vbc_read_port #(
  parameter int DATA_W = vbc_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic rd_in,
  input wire logic hit_pwr3_in,
  input wire logic hit_vctl_in,
  input wire logic [vbc_pkg::PWR3_W-1:0] pwr3_in,
  input wire logic [vbc_pkg::VCTL_W-1:0] vctl_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out
);

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic rvalid;
  } vbc_rp_state_type;

  vbc_rp_state_type state_ff;
  vbc_rp_state_type nxt_state;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_state = state_ff;
    nxt_state.rvalid = rd_in;
    if (rd_in) begin
      // Narrow registers sit in the low bits, upper bits read as zero
      if (hit_pwr3_in) begin
        nxt_state.rdata = DATA_W'(pwr3_in);
      end else if (hit_vctl_in) begin
        nxt_state.rdata = DATA_W'(vctl_in);
      end else begin
        nxt_state.rdata = DATA_W'(vbc_pkg::RDATA_NONE);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rdata_out = state_ff.rdata;
  assign rvalid_out = state_ff.rvalid;

endmodule

// file: design/vbc_video_buffer_control.sv
// Register bank and control outputs of the integrated video output buffer
//
// Contract
// [R01] Power control three bit 4 enables the video buffer; resets to 0.
// [R02] Video control bit 3 selects gain: 0 gives 0dB, 1 gives +6dB.
// [R03] Video control bit 4 raises input low-pass filter Q; resets off.
// [R04] Video control bit 2 at 1 removes the 40mV output floor.
// [R05] Video control bit 1 enables high-impedance input pull-down; resets to 0.
// [R06] Video control bit 0 enables the sync-tip input clamp; resets to 0.
// [R07] Host sets the clamp whenever the video input is AC coupled.
// [R08] AC order: reset, impedance, bias, gain, Q, clamp, pull-down, enable.
// [R09] Host waits 1.5 seconds after enable, then clears the pull-down.
// [R10] DC order: same through Q boost, skip clamp and pull-down, enable last.
// [R11] Host programs reference impedance select: code 10 slowest, 11 fastest.
// [R12] Every single-bit enable is active high: 1 on, 0 off.
`timescale 1ns/1ps
module vbc_video_buffer_control #(
  parameter int ADDR_W = vbc_pkg::ADDR_W,
  parameter int DATA_W = vbc_pkg::DATA_W
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [ADDR_W-1:0] reg_addr_in,
  input wire logic [DATA_W-1:0] reg_wdata_in,
  output logic [DATA_W-1:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic reg_err_out,
  output logic [vbc_pkg::PWR3_W-1:0] power_control_three_out,
  output logic video_path_on_out,
  output logic video_amp_boost_out,
  output logic filter_peaking_raise_out,
  output logic output_floor_remove_out,
  output logic input_sink_on_out,
  output logic sync_tip_clamp_on_out
);

  typedef struct packed {
    logic [vbc_pkg::PWR3_W-1:0] pwr3;
    logic [vbc_pkg::VCTL_W-1:0] vctl;
    logic err;
  } vbc_state_type;

  vbc_state_type state_ff;
  vbc_state_type nxt_state;

  logic hit_pwr3;
  logic hit_vctl;
  logic hit_soft_reset;
  logic unmapped;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  assign hit_pwr3 = (reg_addr_in == ADDR_W'(vbc_pkg::PWR3_ADDR));
  assign hit_vctl = (reg_addr_in == ADDR_W'(vbc_pkg::VCTL_ADDR));
  assign hit_soft_reset = (reg_addr_in == ADDR_W'(vbc_pkg::SOFT_RESET_ADDR));
  assign unmapped = !hit_pwr3 && !hit_vctl && !hit_soft_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Register update

  always_comb begin
    nxt_state = state_ff;
    // Error flag is a one-cycle pulse for any access to an unmapped address
    nxt_state.err = (reg_wr_in || reg_rd_in) && unmapped;
    if (reg_wr_in) begin
      if (hit_soft_reset) begin
        // Any write to the reset address returns every field to default
        nxt_state.pwr3 = vbc_pkg::PWR3_RST; // [R01]
        nxt_state.vctl = vbc_pkg::VCTL_RST; // [R02] [R03] [R05] [R06]
      end else if (hit_pwr3) begin
        nxt_state.pwr3 = reg_wdata_in[vbc_pkg::PWR3_W-1:0]; // [R01]
      end else if (hit_vctl) begin
        // Bits above the five fields are dropped, they read back as zero
        nxt_state.vctl = reg_wdata_in[vbc_pkg::VCTL_W-1:0]; // [R02] [R03] [R04] [R05] [R06]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      state_ff.pwr3 <= vbc_pkg::PWR3_RST; // [R01]
      state_ff.vctl <= vbc_pkg::VCTL_RST; // [R02] [R03] [R05] [R06]
      state_ff.err <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path: a read in the same cycle as a write returns the old value

  vbc_read_port #(
    .DATA_W(DATA_W)
  ) u_read_port (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .rd_in(reg_rd_in),
    .hit_pwr3_in(hit_pwr3),
    .hit_vctl_in(hit_vctl),
    .pwr3_in(state_ff.pwr3),
    .vctl_in(state_ff.vctl),
    .rdata_out(reg_rdata_out),
    .rvalid_out(reg_rvalid_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control outputs, all active high straight from the register bits

  assign reg_err_out = state_ff.err;
  assign power_control_three_out = state_ff.pwr3;
  assign video_path_on_out = state_ff.pwr3[vbc_pkg::PWR3_VIDEO_PATH_ON]; // [R01] [R12]
  assign video_amp_boost_out = state_ff.vctl[vbc_pkg::VCTL_VIDEO_AMP_BOOST]; // [R02]
  assign filter_peaking_raise_out = state_ff.vctl[vbc_pkg::VCTL_FILTER_PEAKING_RAISE]; // [R03] [R12]
  // Driving fully to ground is allowed but clips sync tips on some receivers
  assign output_floor_remove_out = state_ff.vctl[vbc_pkg::VCTL_OUTPUT_FLOOR_REMOVE]; // [R04]
  // Pull-down and clamp are not gated by the buffer enable, so the host may
  // arm them before switching the buffer on
  assign input_sink_on_out = state_ff.vctl[vbc_pkg::VCTL_INPUT_SINK_ON]; // [R05] [R12]
  assign sync_tip_clamp_on_out = state_ff.vctl[vbc_pkg::VCTL_SYNC_TIP_CLAMP_ON]; // [R06] [R12]

endmodule

// file: dv/tb_top.sv
// Self-checking bench for the video buffer control register bank
`timescale 1ns/1ps
module tb_top;
  logic clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0;
  logic [6:0] reg_addr_in = '0;
  logic [8:0] reg_wdata_in = '0, reg_rdata_out, d;
  logic reg_rvalid_out, reg_err_out, video_path_on_out, video_amp_boost_out, filter_peaking_raise_out;
  logic output_floor_remove_out, input_sink_on_out, sync_tip_clamp_on_out;
  logic [7:0] power_control_three_out;
  logic [4:0] v = '0;
  logic [9:0] q[$];
  logic [31:0] seed = 32'h1CFF55CE;
  int n_fail = 0, n_checks = 0, cyc = 0;
  vbc_video_buffer_control u_vbc_video_buffer_control (.*);
  initial forever #12.5 clk_in = ~clk_in;
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge clk_in) if (++cyc == 3000) begin
    n_fail++;
    print_verdict();
  end
  task automatic print_verdict();
    if (n_fail == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string nm, logic [13:0] e, logic [13:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  always @(negedge clk_in) if (reg_rvalid_out === 1'b1) chk("rd", q.pop_front(), {reg_err_out, reg_rdata_out});
  task automatic acc(logic w, logic r, logic [6:0] a, logic [8:0] x);
    @(negedge clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= x;
  endtask
  task automatic rd(logic [6:0] a, logic [9:0] e);
    q.push_back(e);
    acc(0, 1, a, '0);
  endtask
  // Two idle cycles let a write land before the outputs are looked at
  task automatic ctl(logic [7:0] p, logic [4:0] c);
    acc(0, 0, '0, '0);
    acc(0, 0, '0, '0);
    chk("ctl", {p[4], p, c}, {video_path_on_out, power_control_three_out, filter_peaking_raise_out,
      video_amp_boost_out, output_floor_remove_out, input_sink_on_out, sync_tip_clamp_on_out});
  endtask
  initial begin
    repeat (16) @(negedge clk_in);
    sys_rst_in <= 0;
    rd(vbc_pkg::PWR3_ADDR, '0);
    rd(vbc_pkg::VCTL_ADDR, '0);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr_next(seed);
      d = seed[8:0];
      acc(1, 0, vbc_pkg::PWR3_ADDR, d);
      // Read in the same cycle as the write sees the old value
      q.push_back({5'h00, v});
      acc(1, 1, vbc_pkg::VCTL_ADDR, ~d);
      v = ~d[4:0];
      ctl(d[7:0], v);
      rd(vbc_pkg::PWR3_ADDR, {2'b00, d[7:0]});
    end
    for (int i = 0; i < 5; i++) begin
      acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h001 << i);
      ctl(d[7:0], 5'h01 << i);
    end
    // Host power-up for an AC-coupled source; impedance and bias live in another bank
    acc(1, 0, vbc_pkg::SOFT_RESET_ADDR, 9'h000);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h008);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h018);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h019);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h01B);
    acc(1, 0, vbc_pkg::PWR3_ADDR, 9'h010);
    ctl(8'h10, 5'h1B);
    // Settling wait cut to a few cycles, the bank has no timer of its own
    repeat (8) acc(0, 0, '0, '0);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h019);
    ctl(8'h10, 5'h19);
    // DC-coupled source: clamp and pull-down stay off
    acc(1, 0, vbc_pkg::SOFT_RESET_ADDR, 9'h000);
    ctl('0, '0);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h008);
    acc(1, 0, vbc_pkg::VCTL_ADDR, 9'h018);
    acc(1, 0, vbc_pkg::PWR3_ADDR, 9'h010);
    ctl(8'h10, 5'h18);
    // Hardware reset in mid-run must clear what the host programmed
    sys_rst_in <= 1'b1;
    acc(0, 0, '0, '0);
    acc(0, 0, '0, '0);
    sys_rst_in <= 1'b0;
    ctl('0, '0);
    acc(1, 0, vbc_pkg::SOFT_RESET_ADDR, 9'h1FF);
    acc(1, 0, 7'h05, 9'h1FF);
    acc(0, 0, '0, '0);
    chk("err", 14'h0001, 14'(reg_err_out));
    ctl('0, '0);
    rd(7'h05, 10'h200);
    rd(vbc_pkg::VCTL_ADDR, '0);
    ctl('0, '0);
    chk("left", '0, 14'(q.size()));
    print_verdict();
  end
endmodule

// file: dv/vbc_checker.sv
// Port assertions for the video buffer control register bank
`timescale 1ns/1ps
module vbc_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic reg_wr_in,
  input wire logic [6:0] reg_addr_in,
  input wire logic [8:0] reg_wdata_in,
  input wire logic [7:0] power_control_three_out,
  input wire logic video_path_on_out,
  input wire logic video_amp_boost_out,
  input wire logic filter_peaking_raise_out,
  input wire logic output_floor_remove_out,
  input wire logic input_sink_on_out,
  input wire logic sync_tip_clamp_on_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic w3 = reg_wr_in && reg_addr_in == vbc_pkg::PWR3_ADDR;
  wire logic wv = reg_wr_in && reg_addr_in == vbc_pkg::VCTL_ADDR;
  a_path_on_write: assert property (w3 |=> video_path_on_out == $past(reg_wdata_in[4])) else $error("path");
  a_gain_write: assert property (wv |=> video_amp_boost_out == $past(reg_wdata_in[3])) else $error("gain");
  a_peak_write: assert property (wv |=> filter_peaking_raise_out == $past(reg_wdata_in[4])) else $error("q");
  a_floor_write: assert property (wv |=> output_floor_remove_out == $past(reg_wdata_in[2])) else $error("dc");
  a_sink_write: assert property (wv |=> input_sink_on_out == $past(reg_wdata_in[1])) else $error("pd");
  a_clamp_write: assert property (wv |=> sync_tip_clamp_on_out == $past(reg_wdata_in[0])) else $error("cl");
  a_enable_mirror: assert property (video_path_on_out == power_control_three_out[4]) else $error("mir");
  // Without a write nothing may drift
  a_idle_hold: assert property (!reg_wr_in |=> $stable(power_control_three_out) && $stable(sync_tip_clamp_on_out)
    && $stable(input_sink_on_out) && $stable(video_amp_boost_out) && $stable(filter_peaking_raise_out)
    && $stable(output_floor_remove_out)) else $error("hold");
endmodule
bind vbc_video_buffer_control vbc_checker u_vbc_checker (.*);

// file: include/vbc_pkg.sv
// Constants shared by the video buffer control register bank
package vbc_pkg;
  // Control port geometry
  localparam int ADDR_W = 7;
  localparam int DATA_W = 9;

  // Register addresses
  localparam logic [6:0] SOFT_RESET_ADDR = 7'h00;
  localparam logic [6:0] PWR3_ADDR = 7'h03;
  localparam logic [6:0] VCTL_ADDR = 7'h28;

  // Register widths and reset values
  localparam int PWR3_W = 8;
  localparam int VCTL_W = 5;
  localparam logic [7:0] PWR3_RST = 8'h00;
  localparam logic [4:0] VCTL_RST = 5'h00;

  // Field positions in power_control_three
  localparam int PWR3_VIDEO_PATH_ON = 4;

  // Field positions in video_output_control
  localparam int VCTL_FILTER_PEAKING_RAISE = 4;
  localparam int VCTL_VIDEO_AMP_BOOST = 3;
  localparam int VCTL_OUTPUT_FLOOR_REMOVE = 2;
  localparam int VCTL_INPUT_SINK_ON = 1;
  localparam int VCTL_SYNC_TIP_CLAMP_ON = 0;

  // Read data for an unmapped address
  localparam logic [8:0] RDATA_NONE = 9'h000;
endpackage
